// ### rtl/preset_counter_pkg.sv
/*
  Shared constants and types of the preset counter input/output control:
  register offsets, control field layout, reset values, timing counts and
  the enumerations of configuration, input mode, output mode and
  tachometer input mode.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
package preset_counter_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned ONESHOT_MS = 500;
  localparam int unsigned ONESHOT_CYCLES = ONESHOT_MS * (CLK_HZ / 1000);
  localparam int unsigned GATE_MS = 1000;
  localparam int unsigned GATE_CYCLES = GATE_MS * (CLK_HZ / 1000);

  // widths
  localparam int unsigned COUNT_W_DEF = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TMR_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SET1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SET2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PV1 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PV2 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // control register fields
  localparam int unsigned CFG_W = 3;
  localparam int unsigned INM_W = 3;
  localparam int unsigned OUTM_W = 2;
  localparam int unsigned TACH_W = 2;
  localparam int unsigned SINK_W = 4;
  localparam int unsigned KPL_W = 2;
  localparam int unsigned CTRL_CFG_LSB = 0;
  localparam int unsigned CTRL_INM_LSB = 3;
  localparam int unsigned CTRL_OUTM_LSB = 6;
  localparam int unsigned CTRL_TACH_LSB = 8;
  localparam int unsigned CTRL_TWIN_SEL_BIT = 10;
  localparam int unsigned CTRL_SINK_LSB = 11;
  localparam int unsigned CTRL_KPL_LSB = 15;
  localparam int unsigned CTRL_W = 17;

  // status register fields
  localparam int unsigned STAT_OUT_A = 0;
  localparam int unsigned STAT_OUT_B = 1;
  localparam int unsigned STAT_RST_IND = 2;
  localparam int unsigned STAT_KEYS_BLK = 3;
  localparam int unsigned STAT_PIN_LSB = 4;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 17'h00000;
  localparam logic [DATA_W-1:0] SET_RST = 32'h00000000;

  // conditioned input positions
  localparam int unsigned PIN_CNT_A = 0;
  localparam int unsigned PIN_CNT_B = 1;
  localparam int unsigned PIN_RST1 = 2;
  localparam int unsigned PIN_RST2 = 3;
  localparam int unsigned PIN_KEYP = 4;
  localparam int unsigned PIN_FKEY = 5;
  localparam int unsigned PIN_N = 6;

  typedef enum logic [CFG_W-1:0] {
    CFG_ONE_STAGE, CFG_TWO_STAGE, CFG_TOTAL, CFG_BATCH, CFG_DUAL, CFG_TWIN, CFG_TACHO
  } cfg_e;

  typedef enum logic [INM_W-1:0] {
    IN_UP, IN_DOWN, IN_CMD, IN_INDIV, IN_QUAD
  } in_mode_e;

  typedef enum logic [OUTM_W-1:0] {
    OUT_LATCH, OUT_LEVEL, OUT_ONESHOT
  } out_mode_e;

  typedef enum logic [TACH_W-1:0] {
    TACH_SINGLE, TACH_SUM, TACH_INDEP
  } tach_mode_e;

endpackage

// ### rtl/cond_if.sv
/*
  Carrier between the top module and the input conditioner: per-input
  sense inversion going in, active level and one-cycle rising event out.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface cond_if #(
  parameter int unsigned N = 6
);
  logic [N-1:0] inv;
  logic [N-1:0] act;
  logic [N-1:0] rise;

  modport cond (input inv, output act, output rise);
  modport user (output inv, input act, input rise);
endinterface

// ### rtl/input_conditioner.sv
/*
  Input conditioner: two-flop synchroniser per pin, sense inversion,
  registered active level and a one-cycle pulse on each active-going edge.
  Assumes raw inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
module input_conditioner #(
  parameter int unsigned N = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [N-1:0] raw_in,
  cond_if.cond c
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;
  logic [N-1:0] act_q;
  logic [N-1:0] rise_q;
  logic [N-1:0] act_d;

  // sinking inputs read low when on
  assign act_d = sync_q ^ c.inv;
  assign c.act = act_q;
  assign c.rise = rise_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      act_q <= '0;
      rise_q <= '0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      act_q <= act_d;
      rise_q <= act_d & ~act_q;
    end
  end

endmodule

// ### rtl/preset_counter_io_control.sv
/*
  Input and output control of a preset counter that also works as a
  tachometer: count, reset and key-protection pins, present/total/batch
  counts, two set-value outputs and an APB register slave.
  Assumes one 40 MHz clock, an asynchronous active-low reset and pins that
  are asynchronous to the clock.
*/
// Overview of operation
// - single configs: up, down, command, individual, quadrature
// - dual/twin: each input counts its own channel
// - reset clears value and outputs; batch: output b
// - counting blocked while reset held
// - reset loads 0, or final set value counting down
// - reset indicator lit while first reset active
// - second reset lights reset indicator only in tachometer independent mode
// - dual/twin: first reset clears and blocks channel a
// - one/two-stage configs ignore second reset
// - total config: second reset clears, holds total
// - batch: second reset clears batch and output a
// - dual: second reset clears and blocks channel b
// - twin: second reset clears displayed channel, output
// - outputs follow output mode on reaching set value
// - tachometer: input b used unless single mode
// - tachometer: resets hold measurement and outputs
// - tachometer: second reset only in independent mode
// - tachometer: front reset key holds measurement, outputs
// - tachometer: reset indicator lit while holding
// - key protection input blocks keys per level
// - sinking/sourcing per input; key protection sinking
`timescale 1ns/100ps
module preset_counter_io_control #(
  parameter int unsigned COUNT_W = preset_counter_pkg::COUNT_W_DEF,
  parameter int unsigned ONESHOT_CYCLES = preset_counter_pkg::ONESHOT_CYCLES,
  parameter int unsigned GATE_CYCLES = preset_counter_pkg::GATE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [preset_counter_pkg::ADDR_W-1:0] paddr,
  input wire logic [preset_counter_pkg::DATA_W-1:0] pwdata,
  output logic [preset_counter_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic count_reset_input,
  input wire logic total_reset_input,
  input wire logic key_protect_input,
  input wire logic front_reset_key,
  output logic setpoint_output_a,
  output logic setpoint_output_b,
  output logic reset_indicator,
  output logic keys_blocked
);
  import preset_counter_pkg::*;

  if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_width
    $error("COUNT_W must lie between 8 and 32");
  end
  if (ONESHOT_CYCLES < 1 || GATE_CYCLES < 2) begin : g_bad_time
    $error("ONESHOT_CYCLES must be at least 1 and GATE_CYCLES at least 2");
  end

  localparam logic [TMR_W-1:0] ONESHOT_LAST = TMR_W'(ONESHOT_CYCLES - 1);
  localparam logic [TMR_W-1:0] GATE_LAST = TMR_W'(GATE_CYCLES - 1);

  function automatic logic [COUNT_W-1:0] step(input logic [COUNT_W-1:0] v,
                                              input logic up, input logic dn);
    step = v;
    if (up && !dn && v != '1) begin
      step = v + 1'b1;
    end else if (dn && !up && v != '0) begin
      step = v - 1'b1;
    end
  endfunction

  // registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [COUNT_W-1:0] sv1_q;
  logic [COUNT_W-1:0] sv2_q;
  logic [COUNT_W-1:0] pv1_q, pv1_d;
  logic [COUNT_W-1:0] pv2_q, pv2_d;
  logic [COUNT_W-1:0] acc1_q, acc1_d;
  logic [COUNT_W-1:0] acc2_q, acc2_d;
  logic [TMR_W-1:0] gate_q, gate_d;
  logic [1:0] out_q, out_d;
  logic [TMR_W-1:0] tmr_q [2];
  logic [TMR_W-1:0] tmr_d [2];
  logic [1:0] reach_prev_q;
  logic [1:0] reach_w;
  logic [1:0] clr_out_w;
  logic rst_ind_q;
  logic keys_blk_q;
  logic [DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // conditioned inputs
  cond_if #(.N(PIN_N)) cif ();
  wire [PIN_N-1:0] act = cif.act;
  wire [PIN_N-1:0] rise = cif.rise;

  // key protection always sinking, front key internal active high
  assign cif.inv = {1'b0, 1'b1, ctrl_q[CTRL_SINK_LSB +: SINK_W]};

  input_conditioner #(.N(PIN_N)) u_cond (
    .clk(clk),
    .arst_n(arst_n),
    .raw_in({front_reset_key, key_protect_input, total_reset_input,
             count_reset_input, count_input_b, count_input_a}),
    .c(cif.cond)
  );

  // control decode
  wire [CFG_W-1:0] cfg_raw = ctrl_q[CTRL_CFG_LSB +: CFG_W];
  wire [INM_W-1:0] inm_raw = ctrl_q[CTRL_INM_LSB +: INM_W];
  wire [OUTM_W-1:0] outm_raw = ctrl_q[CTRL_OUTM_LSB +: OUTM_W];
  wire [TACH_W-1:0] tach_raw = ctrl_q[CTRL_TACH_LSB +: TACH_W];
  cfg_e cfg;
  in_mode_e in_mode;
  out_mode_e out_mode;
  tach_mode_e tach_mode;
  assign cfg = (cfg_raw > CFG_TACHO) ? CFG_ONE_STAGE : cfg_e'(cfg_raw);
  assign in_mode = (inm_raw > IN_QUAD) ? IN_UP : in_mode_e'(inm_raw);
  assign out_mode = (outm_raw > OUT_ONESHOT) ? OUT_LATCH : out_mode_e'(outm_raw);
  assign tach_mode = (tach_raw > TACH_INDEP) ? TACH_SINGLE : tach_mode_e'(tach_raw);
  wire twin_sel_b = ctrl_q[CTRL_TWIN_SEL_BIT];

  wire is_tacho = cfg == CFG_TACHO;
  wire is_pair = (cfg == CFG_DUAL) || (cfg == CFG_TWIN);
  wire one_stage = (cfg == CFG_ONE_STAGE) || (cfg == CFG_TOTAL);
  wire dec_mode = in_mode == IN_DOWN;

  // key protection and reset sources
  wire key_lock = act[PIN_KEYP] && (ctrl_q[CTRL_KPL_LSB +: KPL_W] != '0);
  wire front_key = act[PIN_FKEY] && !key_lock;
  wire rst1 = act[PIN_RST1] || front_key;
  wire rst2 = act[PIN_RST2];
  wire hold = is_tacho && (rst1 || (tach_mode == TACH_INDEP && rst2));

  // single-channel count events
  wire up_ev = (in_mode == IN_UP || in_mode == IN_INDIV) ? rise[PIN_CNT_A] :
               (in_mode == IN_CMD) ? rise[PIN_CNT_A] && !act[PIN_CNT_B] :
               (in_mode == IN_QUAD) ? (rise[PIN_CNT_A] && !act[PIN_CNT_B]) ||
                                      (rise[PIN_CNT_B] && act[PIN_CNT_A]) :
               1'b0;
  wire dn_ev = (in_mode == IN_DOWN) ? rise[PIN_CNT_A] :
               (in_mode == IN_CMD) ? rise[PIN_CNT_A] && act[PIN_CNT_B] :
               (in_mode == IN_INDIV) ? rise[PIN_CNT_B] :
               (in_mode == IN_QUAD) ? (rise[PIN_CNT_A] && act[PIN_CNT_B]) ||
                                      (rise[PIN_CNT_B] && !act[PIN_CNT_A]) :
               1'b0;

  // tachometer events
  wire tach_a_ev = (tach_mode == TACH_SUM) ? rise[PIN_CNT_A] || rise[PIN_CNT_B] :
                   rise[PIN_CNT_A];
  wire tach_b_ev = (tach_mode == TACH_INDEP) && rise[PIN_CNT_B];
  wire gate_end = gate_q == GATE_LAST;

  // set values and reset load
  wire [COUNT_W-1:0] sv_final = one_stage ? sv1_q : sv2_q;
  wire [COUNT_W-1:0] pv1_load = dec_mode ? sv_final : '0;
  wire [COUNT_W-1:0] sv_gap = (sv_final >= sv1_q) ? sv_final - sv1_q : '0;
  wire batch_ev = reach_w[1] && !reach_prev_q[1];

  // channel clears in dual and twin
  wire clr_pv1 = rst1 || (cfg == CFG_TWIN && rst2 && !twin_sel_b);
  wire clr_pv2 = rst2 && (cfg == CFG_DUAL || twin_sel_b);

  always_comb begin
    pv1_d = pv1_q;
    pv2_d = pv2_q;
    acc1_d = acc1_q;
    acc2_d = acc2_q;
    gate_d = gate_q;
    case (cfg)
      CFG_TACHO: begin
        gate_d = gate_end ? '0 : gate_q + 1'b1;
        acc1_d = gate_end ? '0 : step(acc1_q, tach_a_ev, 1'b0);
        acc2_d = gate_end ? '0 : step(acc2_q, tach_b_ev, 1'b0);
        if (gate_end && !hold) begin
          pv1_d = acc1_q;
          pv2_d = acc2_q;
        end
      end
      CFG_DUAL, CFG_TWIN: begin
        pv1_d = clr_pv1 ? '0 : step(pv1_q, rise[PIN_CNT_A], 1'b0);
        pv2_d = clr_pv2 ? '0 : step(pv2_q, rise[PIN_CNT_B], 1'b0);
      end
      CFG_TOTAL: begin
        pv1_d = rst1 ? pv1_load : step(pv1_q, up_ev, dn_ev);
        pv2_d = rst2 ? '0 : step(pv2_q, up_ev || dn_ev, 1'b0);
      end
      CFG_BATCH: begin
        pv1_d = rst1 ? pv1_load : step(pv1_q, up_ev, dn_ev);
        pv2_d = rst2 ? '0 : step(pv2_q, batch_ev, 1'b0);
      end
      default: begin
        // second reset has no effect here
        pv1_d = rst1 ? pv1_load : step(pv1_q, up_ev, dn_ev);
        pv2_d = '0;
      end
    endcase
  end

  // set value reached
  always_comb begin
    reach_w = 2'b00;
    case (cfg)
      CFG_TACHO: begin
        reach_w[0] = pv1_q >= sv1_q;
        reach_w[1] = ((tach_mode == TACH_INDEP) ? pv2_q : pv1_q) <= sv2_q;
      end
      CFG_DUAL, CFG_TWIN: begin
        reach_w[0] = pv1_q >= sv1_q;
        reach_w[1] = pv2_q >= sv2_q;
      end
      CFG_BATCH: begin
        reach_w[0] = pv2_q >= sv1_q;
        reach_w[1] = dec_mode ? pv1_q == '0 : pv1_q >= sv2_q;
      end
      default: begin
        reach_w[0] = !one_stage && (dec_mode ? pv1_q <= sv_gap : pv1_q >= sv1_q);
        reach_w[1] = dec_mode ? pv1_q == '0 : pv1_q >= sv_final;
      end
    endcase
  end

  // output clears per configuration
  always_comb begin
    clr_out_w = 2'b00;
    case (cfg)
      CFG_TACHO: clr_out_w = 2'b00;
      CFG_BATCH: clr_out_w = {rst1, rst2};
      CFG_DUAL: clr_out_w = {rst2, rst1};
      CFG_TWIN: clr_out_w = {clr_pv2, clr_pv1};
      default: clr_out_w = {rst1, rst1};
    endcase
  end

  // output engine
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < 2; i++) begin
      tmr_d[i] = tmr_q[i];
      if (!hold) begin
        if (clr_out_w[i]) begin
          out_d[i] = 1'b0;
          tmr_d[i] = '0;
        end else begin
          case (out_mode)
            OUT_LEVEL: out_d[i] = reach_w[i];
            OUT_ONESHOT: begin
              if (reach_w[i] && !reach_prev_q[i]) begin
                out_d[i] = 1'b1;
                tmr_d[i] = ONESHOT_LAST;
              end else if (tmr_q[i] != '0) begin
                tmr_d[i] = tmr_q[i] - 1'b1;
              end else begin
                out_d[i] = 1'b0;
              end
            end
            default: out_d[i] = out_q[i] || reach_w[i];
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pv1_q <= '0;
      pv2_q <= '0;
      acc1_q <= '0;
      acc2_q <= '0;
      gate_q <= '0;
      out_q <= '0;
      tmr_q <= '{default: '0};
      reach_prev_q <= '0;
    end else begin
      pv1_q <= pv1_d;
      pv2_q <= pv2_d;
      acc1_q <= acc1_d;
      acc2_q <= acc2_d;
      gate_q <= gate_d;
      out_q <= out_d;
      tmr_q <= tmr_d;
      reach_prev_q <= hold ? reach_prev_q : reach_w;
    end
  end

  // indicators; second reset lights it only in tachometer independent mode
  wire rst_ind_d = is_tacho ? hold : rst1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_ind_q <= 1'b0;
      keys_blk_q <= 1'b0;
    end else begin
      rst_ind_q <= rst_ind_d;
      keys_blk_q <= key_lock;
    end
  end

  // APB slave: registered answer one cycle after setup
  wire sel_ctrl = paddr == OFS_CTRL;
  wire sel_set1 = paddr == OFS_SET1;
  wire sel_set2 = paddr == OFS_SET2;
  wire sel_pv1 = paddr == OFS_PV1;
  wire sel_pv2 = paddr == OFS_PV2;
  wire sel_stat = paddr == OFS_STATUS;
  wire mapped = sel_ctrl || sel_set1 || sel_set2 || sel_pv1 || sel_pv2 || sel_stat;
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

  wire [DATA_W-1:0] status_w = DATA_W'({act, keys_blk_q, rst_ind_q, out_q});
  wire [DATA_W-1:0] rd_mux = sel_ctrl ? DATA_W'(ctrl_q) :
                             sel_set1 ? DATA_W'(sv1_q) :
                             sel_set2 ? DATA_W'(sv2_q) :
                             sel_pv1 ? DATA_W'(pv1_q) :
                             sel_pv2 ? DATA_W'(pv2_q) :
                             sel_stat ? status_w :
                             '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q <= (setup && !pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RST;
      sv1_q <= COUNT_W'(SET_RST);
      sv2_q <= COUNT_W'(SET_RST);
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end
      if (sel_set1) begin
        sv1_q <= pwdata[COUNT_W-1:0];
      end
      if (sel_set2) begin
        sv2_q <= pwdata[COUNT_W-1:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign setpoint_output_a = out_q[0];
  assign setpoint_output_b = out_q[1];
  assign reset_indicator = rst_ind_q;
  assign keys_blocked = keys_blk_q;

endmodule

// ### verification/pcio_chk.sv
/*
  Checker of the preset counter i/o control, bound to its top module.
  Assumes CTRL changes only through APB writes seen at the ports.
*/
`timescale 1ns/100ps
module pcio_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [preset_counter_pkg::ADDR_W-1:0] paddr,
  input wire logic [preset_counter_pkg::DATA_W-1:0] pwdata,
  input wire logic [preset_counter_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic count_reset_input,
  input wire logic total_reset_input,
  input wire logic key_protect_input,
  input wire logic front_reset_key,
  input wire logic setpoint_output_a,
  input wire logic setpoint_output_b,
  input wire logic reset_indicator,
  input wire logic keys_blocked
);
  import preset_counter_pkg::*;
  logic [CTRL_W-1:0] ctrl_q;
  logic [2:0] age_q;
  wire wr_ctrl = psel && penable && pready && pwrite && paddr == OFS_CTRL;
  wire setup = psel && !penable;
  wire settled = age_q >= 3'h2;
  wire tach = settled && ctrl_q[2:0] == CFG_TACHO;
  wire cnt = settled && ctrl_q[2:0] != CFG_TACHO;
  wire single = settled && ctrl_q[2:0] <= CFG_TOTAL;
  wire r1 = count_reset_input ^ ctrl_q[CTRL_SINK_LSB+2];
  wire r2 = total_reset_input ^ ctrl_q[CTRL_SINK_LSB+3];
  wire klock = !key_protect_input && ctrl_q[CTRL_KPL_LSB+1:CTRL_KPL_LSB] != 2'h0;

  // shadow of CTRL and cycles since it last changed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RST;
      age_q <= 3'h0;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  ready_after_setup_a: assert property (setup |=> pready && psel && penable)
    else $error("pready missing after setup");
  ready_only_access_a: assert property (pready |-> $past(setup) && psel && penable)
    else $error("pready outside access cycle");
  err_unmapped_a: assert property (setup && paddr > OFS_STATUS |=> pslverr)
    else $error("no pslverr on unmapped address");
  idle_data_a: assert property (!pready |-> prdata == '0)
    else $error("prdata not zero outside access");
  ctrl_read_a: assert property (setup && !pwrite && paddr == OFS_CTRL
    |=> prdata == {{(DATA_W-CTRL_W){1'b0}}, ctrl_q})
    else $error("ctrl read does not match last write");
  rst_lights_a: assert property ((cnt && r1)[*5] |-> reset_indicator)
    else $error("reset indicator dark during reset");
  rst2_dark_a: assert property ((cnt && r2 && !r1 && !front_reset_key)[*5] |-> !reset_indicator)
    else $error("reset indicator lit by second reset");
  rst_clears_a: assert property ((single && r1)[*5] |-> !setpoint_output_a && !setpoint_output_b)
    else $error("outputs not cleared during reset");
  tach_hold_a: assert property ((tach && r1)[*7] |->
    reset_indicator && $stable(setpoint_output_a) && $stable(setpoint_output_b))
    else $error("tachometer hold not kept");
  keys_lock_a: assert property ((settled && klock)[*5] |-> keys_blocked)
    else $error("keys not blocked");
  keys_free_a: assert property ((key_protect_input)[*5] |-> !keys_blocked)
    else $error("keys blocked without protection");
endmodule

bind preset_counter_io_control pcio_chk chk (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .count_reset_input(count_reset_input),
  .total_reset_input(total_reset_input), .key_protect_input(key_protect_input),
  .front_reset_key(front_reset_key), .setpoint_output_a(setpoint_output_a),
  .setpoint_output_b(setpoint_output_b), .reset_indicator(reset_indicator),
  .keys_blocked(keys_blocked));

// ### verification/field_model.sv
/*
  Sensors, reset switches, key contact and front key at the pins.
  Assumes its tasks are called by one process of the clk domain.
*/
`timescale 1ns/100ps
module field_model (
  input wire logic clk,
  output logic count_input_a,
  output logic count_input_b,
  output logic count_reset_input,
  output logic total_reset_input,
  output logic key_protect_input,
  output logic front_reset_key
);
  logic [5:0] act_q = 6'h00;
  logic [3:0] sink_q = 4'h0;
  // sinking pins are active low; key contact always sinking
  assign count_input_a = act_q[0] ^ sink_q[0];
  assign count_input_b = act_q[1] ^ sink_q[1];
  assign count_reset_input = act_q[2] ^ sink_q[2];
  assign total_reset_input = act_q[3] ^ sink_q[3];
  assign key_protect_input = !act_q[4];
  assign front_reset_key = act_q[5];

  task set_pin(input int i, input logic v);
    @(posedge clk);
    act_q[i] <= v;
  endtask

  task set_sink(input logic [3:0] s);
    @(posedge clk);
    sink_q <= s;
  endtask

  // active and idle phases outlast the synchroniser
  task pulse(input logic [1:0] m, input int len);
    @(posedge clk);
    act_q[1:0] <= act_q[1:0] | m;
    repeat (len) @(posedge clk);
    act_q[1:0] <= act_q[1:0] & ~m;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ### verification/tb_top.sv
/*
  Self-checking bench of the preset counter i/o control.
  Assumes the checker is bound in and field_model drives the pins.
*/
`timescale 1ns/100ps
module tb_top;
  import preset_counter_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdat;
  logic out_a, out_b, rst_ind, keys_blk, cnt_a, cnt_b, rst1, rst2, keyp, fkey;
  int n_fail = 0;
  int check_count = 0;
  int seed = 24;
  int s1;

  preset_counter_io_control #(.COUNT_W(8), .ONESHOT_CYCLES(8), .GATE_CYCLES(16)) uut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_input_a(cnt_a), .count_input_b(cnt_b), .count_reset_input(rst1),
    .total_reset_input(rst2), .key_protect_input(keyp), .front_reset_key(fkey),
    .setpoint_output_a(out_a), .setpoint_output_b(out_b), .reset_indicator(rst_ind),
    .keys_blocked(keys_blk));
  field_model field (.clk(clk), .count_input_a(cnt_a), .count_input_b(cnt_b),
    .count_reset_input(rst1), .total_reset_input(rst2), .key_protect_input(keyp),
    .front_reset_key(fkey));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task end_of_test;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 16) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
    apb(1'b0, a, '0);
    chk(what, exp, rdat);
  endtask

  function automatic logic [DATA_W-1:0] ctrl_w(input int c, input int m, input int s,
                                               input int k);
    return DATA_W'(c) | (DATA_W'(m) << CTRL_INM_LSB) | (DATA_W'(s) << CTRL_SINK_LSB)
      | (DATA_W'(k) << CTRL_KPL_LSB);
  endfunction

  task pl(input logic [1:0] m, input int n);
    repeat (n) field.pulse(m, 3);
  endtask

  // set a pin and let it pass the synchroniser
  task pin(input int i, input logic v);
    field.set_pin(i, v);
    repeat (5) @(posedge clk);
  endtask

  // hold first reset, and second reset when both is set, until the counts clear
  task clr(input int both);
    field.set_pin(2, 1'b1);
    pin(3, both != 0);
    field.set_pin(2, 1'b0);
    pin(3, 1'b0);
  endtask

  task cfg(input logic [DATA_W-1:0] c, input int both);
    apb(1'b1, OFS_CTRL, c);
    clr(both);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rchk(OFS_CTRL, {15'h0000, CTRL_RST}, "ctrl reset");
    rchk(OFS_SET1, SET_RST, "set1 reset");
    rchk(OFS_PV2, 32'h00000000, "pv2 reset");
    rchk(8'h18, 32'h00000000, "unmapped read");
    chk("unmapped err", 32'h00000001, rerr);
    apb(1'b1, OFS_PV1, 32'h00000055);
    rchk(OFS_PV1, 32'h00000000, "pv1 read only");
    s1 = 2 + ($random(seed) & 3);
    apb(1'b1, OFS_SET1, s1);
    apb(1'b1, OFS_SET2, s1 + 3);
    rchk(OFS_SET2, s1 + 3, "set2 readback");
    cfg(ctrl_w(0, 0, 0, 0), 0);
    pl(2'b01, s1 - 2);
    field.pulse(2'b01, 12);
    rchk(OFS_PV1, s1 - 1, "up count");
    chk("out b early", 32'h00000000, out_b);
    pl(2'b01, 1);
    rchk(OFS_PV1, s1, "up reach");
    chk("out b reach", 32'h00000001, out_b);
    pin(2, 1'b1);
    chk("rst indicator", 32'h00000001, rst_ind);
    chk("out b reset", 32'h00000000, out_b);
    pl(2'b01, 2);
    rchk(OFS_PV1, 32'h00000000, "count in reset");
    clr(0);
    pl(2'b01, 2);
    pin(3, 1'b1);
    chk("rst2 indicator", 32'h00000000, rst_ind);
    rchk(OFS_PV1, 32'h00000002, "rst2 ignored");
    field.set_pin(3, 1'b0);
    cfg(ctrl_w(0, 1, 0, 0), 0);
    rchk(OFS_PV1, s1, "down reload");
    pl(2'b01, 1);
    rchk(OFS_PV1, s1 - 1, "down count");
    cfg(ctrl_w(1, 1, 0, 0), 0);
    rchk(OFS_PV1, s1 + 3, "two stage reload");
    cfg(ctrl_w(0, 3, 0, 0), 0);
    pl(2'b01, 3);
    pl(2'b10, 1);
    rchk(OFS_PV1, 32'h00000002, "individual");
    cfg(ctrl_w(0, 2, 0, 0), 0);
    pl(2'b01, 3);
    field.set_pin(1, 1'b1);
    pl(2'b01, 1);
    field.set_pin(1, 1'b0);
    rchk(OFS_PV1, 32'h00000002, "command");
    cfg(ctrl_w(2, 0, 0, 0), 1);
    pl(2'b01, 2);
    rchk(OFS_PV2, 32'h00000002, "total count");
    pin(3, 1'b1);
    pl(2'b01, 1);
    rchk(OFS_PV2, 32'h00000000, "total held");
    rchk(OFS_PV1, 32'h00000003, "present kept");
    field.set_pin(3, 1'b0);
    cfg(ctrl_w(4, 0, 0, 0), 1);
    pl(2'b01, 2);
    pl(2'b10, 3);
    rchk(OFS_PV1, 32'h00000002, "dual a");
    rchk(OFS_PV2, 32'h00000003, "dual b");
    pin(3, 1'b1);
    pl(2'b10, 1);
    rchk(OFS_PV2, 32'h00000000, "dual b reset");
    rchk(OFS_PV1, 32'h00000002, "dual a kept");
    field.set_pin(3, 1'b0);
    pin(2, 1'b1);
    pl(2'b01, 1);
    rchk(OFS_PV1, 32'h00000000, "dual a reset");
    cfg(ctrl_w(32'h00000405, 0, 0, 0), 1);
    pl(2'b11, 2);
    pin(3, 1'b1);
    rchk(OFS_PV2, 32'h00000000, "twin b");
    rchk(OFS_PV1, 32'h00000002, "twin a");
    field.set_sink(4'h1);
    apb(1'b1, OFS_CTRL, ctrl_w(0, 0, 1, 1));
    clr(0);
    pl(2'b01, 2);
    rchk(OFS_PV1, 32'h00000002, "sinking count");
    field.set_pin(4, 1'b1);
    pin(5, 1'b1);
    chk("keys blocked", 32'h00000001, keys_blk);
    chk("front key locked", 32'h00000000, rst_ind);
    field.set_pin(4, 1'b0);
    pin(5, 1'b0);
    chk("keys free", 32'h00000000, keys_blk);
    field.set_pin(2, 1'b1);
    field.set_sink(4'h0);
    apb(1'b1, OFS_CTRL, ctrl_w(6, 0, 0, 0));
    field.pulse(2'b01, 20);
    chk("tach hold lit", 32'h00000001, rst_ind);
    field.set_pin(2, 1'b0);
    field.set_pin(5, 1'b1);
    repeat (8) @(posedge clk);
    chk("tach key hold", 32'h00000001, rst_ind);
    end_of_test();
  end
endmodule
